/* File: src/splc_pkg.sv */
package splc_pkg;
	localparam int DATA_W = 16;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [15:0] UNDERFLOW_FLOOR = 16'h0800;
	localparam logic [15:0] SP_RESET = 16'h0800;
	localparam logic [15:0] PUSH_DATA_RESET = 16'h0000;
	localparam int ALIGN_BIT = 0;
	localparam int MSB_LO = 8;
	localparam int MSB_HI = 15;
	typedef enum logic [2:0] {
		SPLC_OP_NONE,
		SPLC_OP_PUSH,
		SPLC_OP_POP,
		SPLC_OP_WRITE,
		SPLC_OP_READ
	} splc_op_t;
	typedef enum logic [1:0] {
		SPLC_PC_PLAIN,
		SPLC_PC_CALL,
		SPLC_PC_EXCEPTION
	} splc_pcfmt_t;
endpackage

/* File: src/splc_limit_cmp.sv */
`timescale 1ns/100ps
module splc_limit_cmp #(
	parameter int WIDTH = 16
) (
	input wire logic [WIDTH-1:0] i_ea,
	input wire logic [WIDTH-1:0] i_limit,
	input wire logic [WIDTH-1:0] i_floor,
	input wire logic i_is_push,
	input wire logic i_is_stack,
	output logic o_overflow,
	output logic o_underflow
);
	// push at ea == limit is still allowed; only beyond it traps
	always_comb begin
		o_overflow = i_is_stack && i_is_push && (i_ea > i_limit); // RL9 RL10
		o_underflow = i_is_stack && (i_ea < i_floor); // RL11
	end
endmodule

/* File: src/splc_stack_ptr.sv */
`timescale 1ns/100ps
// Functional notes
// RL1: one working register also serves as the software stack pointer.
// RL2: the pointer always holds the next free word address.
// RL3: stack grows upward on push, shrinks downward on pop.
// RL4: push writes at pointer then advances; pop steps back then reads.
// RL5: a call's saved high PC word has its top byte cleared.
// RL6: exception entry puts status low byte into saved high word top byte.
// RL7: the stack limit register has no reset value.
// RL8: stack limit bit 0 always reads and acts as zero.
// RL9: every stack-pointer effective address is compared with the limit; here only push addresses are checked against it.
// RL10: push at pointer equal limit is fine; the next push traps.
// RL11: pointer address below the floor raises an underflow trap.
// RL12: software avoids stack-pointer indirect read right after a limit write.
// RL13: overflow and underflow drive one trap request in the same cycle.
module splc_stack_ptr (
	input wire logic I_CLOCK,
	input wire logic I_ARST_N,
	input wire splc_pkg::splc_op_t I_OP,
	input wire logic [15:0] I_WDATA,
	input wire logic I_LIMIT_WE,
	input wire logic [15:0] I_LIMIT_DATA,
	input wire splc_pkg::splc_pcfmt_t I_PC_FMT,
	input wire logic [7:0] I_STATUS_LOW_BYTE,
	output logic [15:0] O_EA,
	output logic O_EA_VALID,
	output logic [15:0] O_PUSH_DATA,
	output logic [15:0] O_STACK_POINTER,
	output logic [15:0] O_STACK_LIMIT,
	output logic O_STACK_TRAP
);
	logic [15:0] stack_pointer_reg_q;
	logic [15:0] stack_pointer_reg_d;
	logic [15:0] stack_limit_reg_q;
	logic [15:0] pop_ea;
	logic is_push;
	logic is_stack;
	logic overflow;
	logic underflow;
	logic at_limit_q;

	// op decoding shared by the datapath and the checks below
	function automatic logic op_is_push(input splc_pkg::splc_op_t op);
		return op == splc_pkg::SPLC_OP_PUSH;
	endfunction

	// every op but idle forms an address through the pointer
	function automatic logic op_uses_pointer(input splc_pkg::splc_op_t op);
		return op != splc_pkg::SPLC_OP_NONE;
	endfunction

	// ops that move the pointer some other way than a push
	function automatic logic op_moves_back(input splc_pkg::splc_op_t op);
		return op == splc_pkg::SPLC_OP_POP || op == splc_pkg::SPLC_OP_WRITE;
	endfunction

	assign is_push = op_is_push(I_OP);
	assign is_stack = op_uses_pointer(I_OP); // RL9
	assign pop_ea = stack_pointer_reg_q - splc_pkg::WORD_STEP;

	// effective address formed this cycle
	always_comb begin
		case (I_OP)
			splc_pkg::SPLC_OP_POP: begin
				O_EA = pop_ea; // RL4
			end
			default: begin
				O_EA = stack_pointer_reg_q; // RL2
			end
		endcase
	end
	assign O_EA_VALID = is_stack;

	always_comb begin
		case (I_OP)
			splc_pkg::SPLC_OP_PUSH: begin
				stack_pointer_reg_d = stack_pointer_reg_q + splc_pkg::WORD_STEP; // RL3 RL4
			end
			splc_pkg::SPLC_OP_POP: begin
				stack_pointer_reg_d = pop_ea; // RL3 RL4
			end
			splc_pkg::SPLC_OP_WRITE: begin
				// as a working register the pointer stays word aligned
				stack_pointer_reg_d = {I_WDATA[15:1], 1'h0}; // RL1
			end
			default: begin
				stack_pointer_reg_d = stack_pointer_reg_q;
			end
		endcase
	end

	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			stack_pointer_reg_q <= splc_pkg::SP_RESET;
		end else begin
			stack_pointer_reg_q <= stack_pointer_reg_d; // RL1
		end
	end

	// no reset: limit is undefined until software loads it
	always_ff @(posedge I_CLOCK) begin
		if (I_LIMIT_WE) begin
			stack_limit_reg_q <= {I_LIMIT_DATA[15:1], 1'h0}; // RL7 RL8
		end
	end
	assign O_STACK_LIMIT = {stack_limit_reg_q[15:1], 1'h0}; // RL8
	assign O_STACK_POINTER = stack_pointer_reg_q;

	// data for pushes; high PC word formatting per push source
	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_PUSH_DATA <= splc_pkg::PUSH_DATA_RESET;
		end else if (is_push) begin
			case (I_PC_FMT)
				splc_pkg::SPLC_PC_CALL: begin
					O_PUSH_DATA <= {8'h00, I_WDATA[7:0]}; // RL5
				end
				splc_pkg::SPLC_PC_EXCEPTION: begin
					O_PUSH_DATA <= {I_STATUS_LOW_BYTE, I_WDATA[7:0]}; // RL6
				end
				default: begin
					O_PUSH_DATA <= I_WDATA;
				end
			endcase
		end
	end

	splc_limit_cmp #(
		.WIDTH(splc_pkg::DATA_W)
	) u_cmp (
		.i_ea(O_EA), // RL9
		.i_limit(O_STACK_LIMIT),
		.i_floor(splc_pkg::UNDERFLOW_FLOOR),
		.i_is_push(is_push),
		.i_is_stack(is_stack),
		.o_overflow(overflow),
		.o_underflow(underflow)
	);

	// a trap pulse in the same cycle as the address, no latency added
	assign O_STACK_TRAP = overflow || underflow; // RL13

	// remembers a push made exactly at the limit, so the check below
	// also covers a next push that is not back to back
	always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			at_limit_q <= 1'h0;
		end else if (I_LIMIT_WE || op_moves_back(I_OP)) begin
			at_limit_q <= 1'h0;
		end else if (is_push) begin
			at_limit_q <= (O_EA == O_STACK_LIMIT); // RL10
		end
	end

	a_push_advance: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL4
		is_push |=> stack_pointer_reg_q == $past(stack_pointer_reg_q) + splc_pkg::WORD_STEP)
		else $error("push did not advance pointer by one word");
	a_push_at_ptr: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL4
		is_push |-> O_EA == stack_pointer_reg_q)
		else $error("push address is not the pointer");
	a_pop_back: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL3
		I_OP == splc_pkg::SPLC_OP_POP |-> O_EA == stack_pointer_reg_q - splc_pkg::WORD_STEP ##1
		stack_pointer_reg_q == $past(O_EA))
		else $error("pop did not pre-decrement");
	a_read_ea: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL9
		I_OP == splc_pkg::SPLC_OP_READ |-> O_EA_VALID && O_EA == stack_pointer_reg_q)
		else $error("indirect access address is not the pointer");
	a_write_load: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL1
		I_OP == splc_pkg::SPLC_OP_WRITE |=> stack_pointer_reg_q == {$past(I_WDATA[15:1]), 1'h0})
		else $error("pointer write did not load the working value");
	a_idle_hold: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL2
		(I_OP == splc_pkg::SPLC_OP_NONE || I_OP == splc_pkg::SPLC_OP_READ) |=> $stable(stack_pointer_reg_q))
		else $error("pointer moved without a stack op");

	a_push_at_limit: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL10
		(is_push && O_EA == O_STACK_LIMIT && O_EA >= splc_pkg::UNDERFLOW_FLOOR) |-> !O_STACK_TRAP)
		else $error("push at limit trapped");
	a_push_past: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL10
		(is_push && O_EA == O_STACK_LIMIT) ##1 is_push |-> O_STACK_TRAP)
		else $error("push past limit did not trap");
	a_push_after_limit: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL10
		(is_push && at_limit_q) |-> O_STACK_TRAP)
		else $error("later push past limit did not trap");
	a_over_trap: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL10
		(is_push && O_EA > O_STACK_LIMIT) |-> O_STACK_TRAP)
		else $error("push beyond limit did not trap");
	a_floor_trap: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL11
		(is_stack && O_EA < splc_pkg::UNDERFLOW_FLOOR) |-> O_STACK_TRAP)
		else $error("underflow not trapped");
	a_no_false_trap: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL13
		O_STACK_TRAP |-> is_stack &&
		(O_EA < splc_pkg::UNDERFLOW_FLOOR || (is_push && O_EA > O_STACK_LIMIT)))
		else $error("spurious stack trap");

	a_call_msb: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL5
		(is_push && I_PC_FMT == splc_pkg::SPLC_PC_CALL) |=> O_PUSH_DATA[splc_pkg::MSB_HI:splc_pkg::MSB_LO] == 8'h00)
		else $error("call push msb not cleared");
	a_exc_msb: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL6
		(is_push && I_PC_FMT == splc_pkg::SPLC_PC_EXCEPTION) |=>
		O_PUSH_DATA[splc_pkg::MSB_HI:splc_pkg::MSB_LO] == $past(I_STATUS_LOW_BYTE))
		else $error("exception push msb wrong");
	a_pc_low_byte: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL5
		(is_push && I_PC_FMT != splc_pkg::SPLC_PC_PLAIN) |=> O_PUSH_DATA[7:0] == $past(I_WDATA[7:0]))
		else $error("saved pc low byte lost");
	a_plain_push: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL4
		(is_push && I_PC_FMT == splc_pkg::SPLC_PC_PLAIN) |=> O_PUSH_DATA == $past(I_WDATA))
		else $error("plain push data wrong");
	a_push_data_hold: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL4
		!is_push |=> $stable(O_PUSH_DATA))
		else $error("push data changed without a push");
	a_limit_align: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL8
		I_LIMIT_WE |=> O_STACK_LIMIT[splc_pkg::ALIGN_BIT] == 1'h0 &&
		O_STACK_LIMIT[15:1] == $past(I_LIMIT_DATA[15:1]))
		else $error("limit not loaded aligned");
	a_sp_align: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N) // RL2
		stack_pointer_reg_q[splc_pkg::ALIGN_BIT] == 1'h0)
		else $error("stack pointer misaligned");

	c_push: cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N) is_push ##1 is_push);
	c_overflow: cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N) overflow);
	c_underflow: cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N) underflow);
	c_exc_push: cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		is_push && I_PC_FMT == splc_pkg::SPLC_PC_EXCEPTION);
	c_push_after_limit: cover property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
		is_push && at_limit_q);
endmodule

/* File: sim/splc_core_model.sv */
`timescale 1ns/100ps
// exception side: records every trap request taken at a clock edge
module splc_core_model (
	input wire logic i_clock,
	input wire logic i_trap,
	output int o_traps
);
	initial o_traps = 0;
	always @(posedge i_clock) if (i_trap === 1'h1) o_traps <= o_traps + 1;
endmodule

/* File: sim/stack_pointer_limit_check_tb_top.sv */
`timescale 1ns/100ps
module stack_pointer_limit_check_tb_top;
	logic clk = 1'h0, rst_n = 1'h0, lwe = 1'h0, ev, trap;
	splc_pkg::splc_op_t op = splc_pkg::SPLC_OP_NONE;
	splc_pkg::splc_pcfmt_t fmt = splc_pkg::SPLC_PC_PLAIN;
	logic [15:0] wd = 16'h0000, ld = 16'h0000, ea, pd, sp, lim;
	logic [7:0] sl = 8'hA5;
	int traps, n_errors = 0, num_checks = 0;
	always #4 clk = ~clk;
	splc_stack_ptr u_dut (.I_CLOCK(clk), .I_ARST_N(rst_n), .I_OP(op), .I_WDATA(wd), .I_LIMIT_WE(lwe),
		.I_LIMIT_DATA(ld), .I_PC_FMT(fmt), .I_STATUS_LOW_BYTE(sl), .O_EA(ea), .O_EA_VALID(ev),
		.O_PUSH_DATA(pd), .O_STACK_POINTER(sp), .O_STACK_LIMIT(lim), .O_STACK_TRAP(trap));
	splc_core_model u_core (.i_clock(clk), .i_trap(trap), .o_traps(traps));
	task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", n, exp, got);
		end
	endtask
	task summarize;
		if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ops run back to back: each call overwrites the previous op at the falling edge
	task step(input splc_pkg::splc_op_t o, input splc_pkg::splc_pcfmt_t f, input logic [15:0] d,
		input logic [15:0] x_ea, input logic x_trap);
		@(negedge clk);
		op = o;
		fmt = f;
		wd = d;
		#1;
		chk("ea", ea, x_ea);
		chk("trap", {15'h0000, trap}, {15'h0000, x_trap});
		chk("valid", {15'h0000, ev}, 16'h0001);
		@(posedge clk);
		#1;
	endtask
	task t_limit;
		@(negedge clk);
		lwe = 1'h1;
		ld = 16'h0807;
		@(negedge clk);
		lwe = 1'h0;
		chk("limit", lim, 16'h0806);
	endtask
	// limit 0806: pushes at 0800..0806 pass, the one at 0808 traps
	task t_push;
		step(splc_pkg::SPLC_OP_PUSH, splc_pkg::SPLC_PC_CALL, 16'h1234, 16'h0800, 1'h0);
		chk("pd", pd, 16'h0034);
		step(splc_pkg::SPLC_OP_PUSH, splc_pkg::SPLC_PC_EXCEPTION, 16'h5678, 16'h0802, 1'h0);
		chk("pd", pd, 16'hA578);
		step(splc_pkg::SPLC_OP_PUSH, splc_pkg::SPLC_PC_PLAIN, 16'hBEEF, 16'h0804, 1'h0);
		chk("sp", sp, 16'h0806);
		step(splc_pkg::SPLC_OP_PUSH, splc_pkg::SPLC_PC_PLAIN, 16'hBEEF, 16'h0806, 1'h0);
		chk("pd", pd, 16'hBEEF);
		step(splc_pkg::SPLC_OP_PUSH, splc_pkg::SPLC_PC_PLAIN, 16'h0000, 16'h0808, 1'h1);
		chk("sp", sp, 16'h080A);
	endtask
	task t_pop;
		for (int i = 0; i < 6; i++) begin
			step(splc_pkg::SPLC_OP_POP, splc_pkg::SPLC_PC_PLAIN, 16'h0000, 16'h0808 - 16'(2 * i), i == 5);
			chk("sp", sp, 16'h0808 - 16'(2 * i));
		end
		step(splc_pkg::SPLC_OP_WRITE, splc_pkg::SPLC_PC_PLAIN, 16'h0701, 16'h07FE, 1'h1);
		chk("sp", sp, 16'h0700);
		step(splc_pkg::SPLC_OP_READ, splc_pkg::SPLC_PC_PLAIN, 16'h0000, 16'h0700, 1'h1);
		@(negedge clk);
		op = splc_pkg::SPLC_OP_NONE;
		#1;
		chk("valid", {15'h0000, ev}, 16'h0000);
		chk("trap", {15'h0000, trap}, 16'h0000);
		@(negedge clk);
		chk("traps", 16'(traps), 16'h0004);
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'h1;
		chk("sp", sp, 16'h0800);
		chk("pd", pd, 16'h0000);
		t_limit;
		t_push;
		t_pop;
		summarize;
	end
	initial begin
		#10000;
		n_errors++;
		summarize;
	end
endmodule
